// *** sdc_pkg.sv ***
package sdc_pkg;

    // ------------------------------------------------------------
    // Frame and inputs
    // ------------------------------------------------------------
    localparam int          FRAME_BITS   = 24;          // Bits per command frame
    localparam int          NUM_PROG     = 8;           // Programmable inputs
    localparam int          NUM_GND      = 14;          // Ground-only inputs
    localparam int          NUM_IN       = 22;          // All inputs
    localparam int          RESET_FLAG_BIT = 22;        // Reset flag position in reply

    // ------------------------------------------------------------
    // Opcodes (bits 23..16)
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_STATUS    = 8'h00;       // Status read only
    localparam logic [7:0]  OP_SENSE     = 8'h01;       // Sense polarity
    localparam logic [7:0]  OP_WAKE_PRG  = 8'h02;       // Wake enable, programmable
    localparam logic [7:0]  OP_WAKE_GND  = 8'h03;       // Wake enable, ground
    localparam logic [7:0]  OP_LVL_PRG   = 8'h04;       // Wetting level, programmable
    localparam logic [7:0]  OP_LVL_GND   = 8'h05;       // Wetting level, ground
    localparam logic [7:0]  OP_TMR_PRG   = 8'h07;       // Timer enable, programmable
    localparam logic [7:0]  OP_TMR_GND   = 8'h08;       // Timer enable, ground
    localparam logic [7:0]  OP_RESET     = 8'h7F;       // Reset command

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_PROG     = 8'hFF;       // All ones: battery, wake, high, timer
    localparam logic [13:0] RST_GND      = 14'h3FFF;    // All ones for ground inputs

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ       = 100_000_000; // System clock rate
    localparam int          WET_TIME_MS  = 20;          // Wetting timer length
    localparam int          WET_CYCLES   = (CLK_HZ / 1000) * WET_TIME_MS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] gnd;                               // Ground inputs
        logic [7:0]  prog;                              // Programmable inputs
    } sdc_inputs_t;

    typedef struct packed {
        logic        sclk;                              // Serial clock
        logic        cs_n;                              // Chip select
        logic        si;                                // Serial data in
    } sdc_serial_t;

endpackage : sdc_pkg

// *** sdc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; output moves once stages two and three agree
module sdc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_q;        // Metastable stage, read only by s2
    logic [W-1:0] s2_q;        // Second stage
    logic [W-1:0] s3_q;        // Third stage

    // ------------------------------------------------------------
    // Shift chain
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ------------------------------------------------------------
    // Agreement filter, per bit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s2_q[i];
                end
            end
        end
    end

endmodule : sdc_sync

`default_nettype wire

// *** sdc_wet_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// One input's wetting-current timer and current level
module sdc_wet_timer #(
    parameter int CYCLES = 2_000_000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Control
    input  wire logic restart,      // Clears timer (reset command)
    input  wire logic crossed,      // Input crossed the threshold
    input  wire logic closed,       // Contact is closed
    input  wire logic level_hi,     // Programmed high level
    input  wire logic tmr_en,       // Timer enabled
    // Result
    output logic      high_cur      // High wetting current applied
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] cnt_q;           // Elapsed cycles
    logic          expired_q;       // Timer ran out

    // ------------------------------------------------------------
    // Counter, started on each threshold crossing
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (restart || crossed) begin
            cnt_q     <= '0;
            expired_q <= 1'b0;
        end else if (closed && !expired_q) begin
            if (cnt_q == CW'(CYCLES - 1)) begin
                expired_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Level: disabled timer keeps high current forever
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            high_cur <= 1'b0;
        end else begin
            high_cur <= level_hi && (!tmr_en || !expired_q);
        end
    end

endmodule : sdc_wet_timer

`default_nettype wire

// *** sdc_top.sv ***
`timescale 1ns/10ps
`default_nettype none

module sdc_top #(
    parameter int WET_CYCLES = sdc_pkg::WET_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,        // Power-on reset from battery supply
    // Serial link
    input  wire logic        SCLK,
    input  wire logic        CS_N,
    input  wire logic        SI,
    output logic             SO,
    output logic             SO_OE,
    // Supply and wake
    input  wire logic        LOGIC_SUPPLY_OK,
    input  wire logic        WAKE_N_IN,
    output logic             WAKE_N_OUT,
    output logic             WAKE_N_OE,
    input  wire logic        INT_N_IN,
    output logic             INT_N_OUT,
    output logic             INT_N_OE,
    input  wire logic        IRQ_TIMER_EXPIRED,
    // Switch comparators (1 = above threshold)
    input  wire logic [21:0] COMP_ABOVE,
    // Current and mode outputs
    output logic [21:0]      WET_HIGH,
    output logic [7:0]       SENSE_BATTERY,
    output logic             NORMAL_MODE
);

    // ------------------------------------------------------------
    // Synchronised pins
    // ------------------------------------------------------------
    sdc_pkg::sdc_serial_t ser_raw;      // Raw serial pins
    sdc_pkg::sdc_serial_t ser;          // Filtered serial pins
    logic [21:0]          comp_s;       // Filtered comparators
    logic [2:0]           misc_s;       // Wake, int, supply
    logic                 wake_s;       // Wake pin level
    logic                 intp_s;       // Interrupt pin level
    logic                 vdd_s;        // Logic supply present

    assign ser_raw = '{sclk: SCLK, cs_n: CS_N, si: SI};

    sdc_sync #(.W(3)) u_sync_ser (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      (ser_raw),
        .q      (ser)
    );

    sdc_sync #(.W(22)) u_sync_comp (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      (COMP_ABOVE),
        .q      (comp_s)
    );

    sdc_sync #(.W(3)) u_sync_misc (
        .clk    (CLK),
        .arst_n (ARST_N),
        .d      ({WAKE_N_IN, INT_N_IN, LOGIC_SUPPLY_OK}),
        .q      (misc_s)
    );

    assign wake_s = misc_s[2];
    assign intp_s = misc_s[1];
    assign vdd_s  = misc_s[0];

    // ------------------------------------------------------------
    // Edge detection on filtered levels
    // ------------------------------------------------------------
    logic       sclk_q;         // Previous serial clock
    logic       cs_q;           // Previous chip select
    logic       wake_q;         // Previous wake pin
    logic       intp_q;         // Previous interrupt pin
    logic [21:0] comp_q;        // Previous comparators
    logic [2:0] boot_q;         // Cycles since reset, held once pins settle
    logic       booted;         // Synchronised pins valid, edges trusted

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
            wake_q <= 1'b1;
            intp_q <= 1'b1;
            comp_q <= '0;
            boot_q <= '0;
        end else begin
            sclk_q <= ser.sclk;
            cs_q   <= ser.cs_n;
            wake_q <= wake_s;
            intp_q <= intp_s;
            comp_q <= comp_s;
            // Synchronisers reset low, unlike idle pins: hold off edges until settled
            boot_q <= (boot_q == 3'h5) ? boot_q : boot_q + 3'h1;
        end
    end

    logic        cs_fall;       // Frame start
    logic        cs_rise;       // Frame end
    logic        sclk_fall;     // Sample point
    logic        sclk_rise;     // Shift-out point
    logic [21:0] crossed;       // Comparator changed (needs one settled cycle)
    logic [21:0] closed;        // Contact closed, polarity applied

    assign booted    = (boot_q == 3'h5);
    assign cs_fall   = cs_q && !ser.cs_n && booted;
    assign cs_rise   = !cs_q && ser.cs_n && booted;
    assign sclk_fall = sclk_q && !ser.sclk && !ser.cs_n;
    assign sclk_rise = !sclk_q && ser.sclk && !ser.cs_n;
    assign crossed   = booted ? (comp_s ^ comp_q) : '0;

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0]  sense_q;       // input_sense_polarity
    logic [7:0]  wake_prg_q;    // wake_irq_enable_prog
    logic [13:0] wake_gnd_q;    // wake_irq_enable_gnd
    logic [7:0]  lvl_prg_q;     // wetting_level_prog
    logic [13:0] lvl_gnd_q;     // wetting_level_gnd
    logic [7:0]  tmr_prg_q;     // wetting_timer_enable_prog
    logic [13:0] tmr_gnd_q;     // wetting_timer_enable_gnd

    // Closed: battery sense closes high, ground sense and gnd inputs close low
    always_comb begin
        for (int i = 0; i < sdc_pkg::NUM_PROG; i++) begin
            closed[i] = sense_q[i] ? comp_s[i] : !comp_s[i];
        end
        closed[21:8] = ~comp_s[21:8];
    end

    // ------------------------------------------------------------
    // Serial shift registers
    // ------------------------------------------------------------
    logic [23:0] rx_q;          // Command shift-in
    logic [23:0] tx_q;          // Status shift-out
    logic [4:0]  bits_q;        // Falling clocks seen this frame
    logic        rst_flag_q;    // Reset has occurred
    logic        normal_q;      // Normal mode
    logic        wr_ok;         // Frame may program registers
    logic        cmd_rst;       // Reset command accepted

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rx_q   <= '0;
            bits_q <= '0;
        end else if (cs_fall) begin
            bits_q <= '0;
        end else if (sclk_fall) begin
            rx_q   <= {rx_q[22:0], ser.si};
            if (bits_q != 5'h1F) begin
                bits_q <= bits_q + 5'h01;
            end
        end
    end

    // Reply word: captured on chip select fall, MSB first out
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tx_q <= '0;
        end else if (cs_fall) begin
            tx_q <= {1'b0, rst_flag_q, closed};
        end else if (sclk_rise && bits_q != 5'h00) begin
            tx_q <= {tx_q[22:0], 1'b0};
        end
    end

    // Pin: first bit shows after chip select falls
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SO    <= 1'b0;
            SO_OE <= 1'b0;
        end else begin
            SO    <= tx_q[23];
            SO_OE <= booted && !ser.cs_n && !cs_fall;
        end
    end

    // Write acceptance: full frame, Normal, logic supply
    assign wr_ok   = cs_rise && bits_q == 5'(sdc_pkg::FRAME_BITS)
                     && normal_q && vdd_s;
    assign cmd_rst = wr_ok && rx_q[23:16] == sdc_pkg::OP_RESET;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sense_q    <= sdc_pkg::RST_PROG;
            wake_prg_q <= sdc_pkg::RST_PROG;
            wake_gnd_q <= sdc_pkg::RST_GND;
            lvl_prg_q  <= sdc_pkg::RST_PROG;
            lvl_gnd_q  <= sdc_pkg::RST_GND;
            tmr_prg_q  <= sdc_pkg::RST_PROG;
            tmr_gnd_q  <= sdc_pkg::RST_GND;
        end else if (cmd_rst) begin
            sense_q    <= sdc_pkg::RST_PROG;
            wake_prg_q <= sdc_pkg::RST_PROG;
            wake_gnd_q <= sdc_pkg::RST_GND;
            lvl_prg_q  <= sdc_pkg::RST_PROG;
            lvl_gnd_q  <= sdc_pkg::RST_GND;
            tmr_prg_q  <= sdc_pkg::RST_PROG;
            tmr_gnd_q  <= sdc_pkg::RST_GND;
        end else if (wr_ok) begin
            case (rx_q[23:16])
                sdc_pkg::OP_SENSE:    sense_q    <= rx_q[7:0];
                sdc_pkg::OP_WAKE_PRG: wake_prg_q <= rx_q[7:0];
                sdc_pkg::OP_WAKE_GND: wake_gnd_q <= rx_q[13:0];
                sdc_pkg::OP_LVL_PRG:  lvl_prg_q  <= rx_q[7:0];
                sdc_pkg::OP_LVL_GND:  lvl_gnd_q  <= rx_q[13:0];
                sdc_pkg::OP_TMR_PRG:  tmr_prg_q  <= rx_q[7:0];
                sdc_pkg::OP_TMR_GND:  tmr_gnd_q  <= rx_q[13:0];
                default: begin
                end
            endcase
        end
    end

    // Reset flag: set by any reset, cleared at frame end; reset command wins
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_flag_q <= 1'b1;
        end else if (cmd_rst) begin
            rst_flag_q <= 1'b1;
        end else if (cs_rise) begin
            rst_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode: Normal after reset and never left; wake events and reset command only re-assert it
    // ------------------------------------------------------------
    logic [21:0] wake_en;       // Combined wake/interrupt enables
    logic        sw_event;      // Enabled switch changed
    logic        wake_event;    // Any Normal-entry event

    assign wake_en    = {wake_gnd_q, wake_prg_q};
    assign sw_event   = |(crossed & wake_en);
    assign wake_event = sw_event
                        || (booted && wake_q && !wake_s)
                        || (booted && intp_q && !intp_s && vdd_s && wake_s)
                        || (cs_fall && vdd_s)
                        || IRQ_TIMER_EXPIRED;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            normal_q <= 1'b1;
        end else if (wake_event || cmd_rst) begin
            normal_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt: set on enabled change, released on frame end unless an enabled contact closed in that frame
    // ------------------------------------------------------------
    logic irq_q;                // Interrupt asserted
    logic closed_in_frame_q;    // Contact closed while selected

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            closed_in_frame_q <= 1'b0;
        end else if (!ser.cs_n && |(crossed & closed & wake_en)) begin
            closed_in_frame_q <= 1'b1;      // Closure at frame start still counts
        end else if (cs_fall) begin
            closed_in_frame_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_q <= 1'b0;
        end else if (normal_q && sw_event) begin
            irq_q <= 1'b1;
        end else if (cs_rise && !closed_in_frame_q) begin
            irq_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Wetting timers, one per input
    // ------------------------------------------------------------
    logic [21:0] lvl_all;       // Levels, gnd above prog
    logic [21:0] tmr_all;       // Timer enables
    logic [21:0] high_cur;      // Per-input high current

    assign lvl_all = {lvl_gnd_q, lvl_prg_q};
    assign tmr_all = {tmr_gnd_q, tmr_prg_q};

    for (genvar g = 0; g < sdc_pkg::NUM_IN; g++) begin : g_wet
        sdc_wet_timer #(.CYCLES(WET_CYCLES)) u_wet (
            .clk      (CLK),
            .arst_n   (ARST_N),
            .restart  (cmd_rst),
            .crossed  (crossed[g]),
            .closed   (closed[g]),
            .level_hi (lvl_all[g]),
            .tmr_en   (tmr_all[g]),
            .high_cur (high_cur[g])
        );
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WET_HIGH      <= '0;
            SENSE_BATTERY <= sdc_pkg::RST_PROG;
            NORMAL_MODE   <= 1'b0;
            INT_N_OUT     <= 1'b0;
            INT_N_OE      <= 1'b0;
            WAKE_N_OUT    <= 1'b0;
            WAKE_N_OE     <= 1'b0;
        end else begin
            WET_HIGH      <= high_cur;
            SENSE_BATTERY <= sense_q;
            NORMAL_MODE   <= normal_q;
            INT_N_OUT     <= 1'b0;
            INT_N_OE      <= irq_q;
            WAKE_N_OUT    <= 1'b0;
            WAKE_N_OE     <= normal_q;
        end
    end

endmodule : sdc_top

`default_nettype wire

// *** sdc_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------
// Checker
// ----------
module sdc_checker (
    // Clock and reset
    input wire logic       CLK,
    input wire logic       ARST_N,
    // Watched ports
    input wire logic       CS_N,
    input wire logic       LOGIC_SUPPLY_OK,
    input wire logic       SO_OE,
    input wire logic       WAKE_N_OE,
    input wire logic       INT_N_OE,
    input wire logic [7:0] SENSE_BATTERY,
    input wire logic       NORMAL_MODE
);
    // One domain; the first edge after reset sees $past low
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    AST_MODE: assert property ($past(ARST_N) |-> NORMAL_MODE)
        else $error("not in normal mode");
    AST_WAKE: assert property ($past(ARST_N) |-> WAKE_N_OE == NORMAL_MODE)
        else $error("wake pin disagrees with mode");
    AST_SO_ON: assert property (LOGIC_SUPPLY_OK && $fell(CS_N) |-> ##[1:8] SO_OE)
        else $error("reply driver not enabled");
    AST_SO_OFF: assert property ($rose(CS_N) |-> ##[1:8] !SO_OE)
        else $error("reply driver not released");
    AST_INT_CLR: assert property ($fell(INT_N_OE) |-> CS_N)
        else $error("interrupt released with select low");
    AST_INT_HOLD: assert property (INT_N_OE && !CS_N |=> INT_N_OE)
        else $error("interrupt dropped inside a frame");
    AST_CFG_CS: assert property (!$stable(SENSE_BATTERY) |-> CS_N)
        else $error("settings changed inside a frame");
    AST_CFG_VDD: assert property (!$stable(SENSE_BATTERY) |-> LOGIC_SUPPLY_OK)
        else $error("settings changed without supply");
endmodule : sdc_checker
bind sdc_top sdc_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .CS_N(CS_N),
    .LOGIC_SUPPLY_OK(LOGIC_SUPPLY_OK), .SO_OE(SO_OE), .WAKE_N_OE(WAKE_N_OE),
    .INT_N_OE(INT_N_OE), .SENSE_BATTERY(SENSE_BATTERY), .NORMAL_MODE(NORMAL_MODE));
`default_nettype wire

// *** sdc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ----------
// Host model
// ----------
module sdc_host (
    // Serial link
    output var logic SCLK,
    output var logic CS_N,
    output var logic SI,
    input  wire logic SO
);
    // Idle: deselected, clock low
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI   = 1'b0;
    end
    // Frame of n bits, 125 ns each; SI moves only well after a fall
    task automatic xfer(input logic [23:0] c, input int n, output logic [23:0] r);
        r = '0;
        SI = c[23];
        CS_N = 1'b0;
        #100;
        for (int i = 23; i > 23 - n; i--) begin
            #12.5 SCLK = 1'b1;
            #62.5 r[i] = SO;
            SCLK = 1'b0;
            #50;
            if (i > 0) SI = c[i - 1];
        end
        CS_N = 1'b1;
        SI = ~SI; // Deselected line carries no stale bit
        #200;
    endtask : xfer
endmodule : sdc_host
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ----------
    // Signals
    // ----------
    logic        clk, arst_n, supply_ok;
    logic [21:0] comp;       // Comparator levels
    logic [23:0] rsp;        // Last reply
    wire logic   sclk, cs_n, si, so, so_oe, normal, wk_out, wk_oe, in_out, in_oe;
    wire logic [21:0] wet;
    wire logic [7:0]  sense;
    int          checks, n_mismatch;
    logic [7:0]  ops [4] = '{sdc_pkg::OP_TMR_PRG, sdc_pkg::OP_TMR_GND,
                             sdc_pkg::OP_LVL_PRG, sdc_pkg::OP_LVL_GND};
    logic [1:0]  exps [4] = '{2'b01, 2'b11, 2'b10, 2'b00}; // {wet 8, wet 0}
    // Open-drain pins pulled up when released
    sdc_top #(.WET_CYCLES(50)) dut (.CLK(clk), .ARST_N(arst_n), .SCLK(sclk),
        .CS_N(cs_n), .SI(si), .SO(so), .SO_OE(so_oe), .LOGIC_SUPPLY_OK(supply_ok),
        .WAKE_N_IN(wk_oe ? wk_out : 1'b1), .WAKE_N_OUT(wk_out), .WAKE_N_OE(wk_oe),
        .INT_N_IN(in_oe ? in_out : 1'b1), .INT_N_OUT(in_out), .INT_N_OE(in_oe),
        .IRQ_TIMER_EXPIRED(1'b0), .COMP_ABOVE(comp), .WET_HIGH(wet),
        .SENSE_BATTERY(sense), .NORMAL_MODE(normal));
    sdc_host host (.SCLK(sclk), .CS_N(cs_n), .SI(si), .SO(so));
    // ----------
    // Tasks
    // ----------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input logic [7:0] op, input logic [15:0] d);
        host.xfer({op, d}, 24, rsp);
    endtask : cmd
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300_000;
        n_mismatch++;
        end_sim();
    end
    // ----------
    // Sequence
    // ----------
    initial begin
        checks = 0;
        n_mismatch = 0;
        arst_n = 1'b0;
        supply_ok = 1'b1;
        comp = 22'h3F_FF00; // All inputs open
        tick(5);
        arst_n = 1'b1;
        tick(20);
        chk(24'(normal), 24'h00_0001);
        chk(24'(sense), 24'h00_00FF);
        chk(24'(wet), 24'h3F_FFFF);
        cmd(sdc_pkg::OP_STATUS, 16'h0000);
        chk(rsp, 24'h40_0000);
        comp = 22'h3F_FE01; // Close one programmable and one ground input
        tick(10);
        chk(24'({in_oe, wet[8], wet[0]}), 24'h00_0007);
        tick(60);
        chk(24'({wet[8], wet[0]}), 24'h00_0000);
        cmd(sdc_pkg::OP_STATUS, 16'h0000);
        chk(rsp, 24'h00_0101);
        chk(24'(in_oe), 24'h00_0000);
        for (int k = 0; k < 4; k++) begin
            cmd(ops[k], 16'h0000);
            chk(24'({wet[8], wet[0]}), 24'(exps[k]));
        end
        cmd(sdc_pkg::OP_SENSE, 16'hFF0F);
        chk(24'(sense), 24'h00_000F);
        cmd(sdc_pkg::OP_STATUS, 16'h0000);
        chk(rsp, 24'h00_01F1);
        cmd(8'h40, 16'h00F0);
        chk(24'(sense), 24'h00_000F);
        host.xfer({sdc_pkg::OP_SENSE, 16'h00F0}, 23, rsp);
        chk(24'(sense), 24'h00_000F);
        tick(1);
        supply_ok = 1'b0;
        tick(10);
        cmd(sdc_pkg::OP_SENSE, 16'h00F0);
        chk(24'(sense), 24'h00_000F);
        tick(1);
        supply_ok = 1'b1;
        cmd(sdc_pkg::OP_WAKE_PRG, 16'h0000);
        cmd(sdc_pkg::OP_WAKE_GND, 16'h0000);
        tick(1);
        comp[1] = 1'b1;
        tick(20);
        chk(24'(in_oe), 24'h00_0000);
        cmd(sdc_pkg::OP_WAKE_PRG, 16'h0002);
        tick(1);
        comp[1] = 1'b0;
        tick(20);
        chk(24'(in_oe), 24'h00_0001);
        // Closure while selected must survive the select rise
        fork
            cmd(sdc_pkg::OP_STATUS, 16'h0000);
            begin
                tick(100);
                comp[1] = 1'b1;
            end
        join
        chk(24'(in_oe), 24'h00_0001);
        cmd(sdc_pkg::OP_STATUS, 16'h0000);
        chk(24'(in_oe), 24'h00_0000);
        cmd(sdc_pkg::OP_RESET, 16'h0000);
        chk(24'({sense, wet[0]}), 24'h00_01FF);
        cmd(sdc_pkg::OP_STATUS, 16'h0000);
        chk(rsp, 24'h40_0103);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
